// ### hdl/ihp_top.sv
// Function
// - two identical host ports, own pins and irq
// - each port target by default, master selectable
// - per-port mask selects events driving irq
// - aux port always master, no irq, bitbang
// - aux first pin clock, second pin data
// - target works at standard and fast rates
// - start is data falling while clock high
// - matching address acked low on ninth clock
// - one bit per clock, data moves clock-low
// - stop is data rising while clock high
// - bytes of eight bits plus one ack
// - transmitter releases data before ack clock
// - target receiver acks every received byte
// - master nack ends read, target releases data
// - target stretches clock low while not ready
// - stretch only in the clock low after an ack clock
// - address is 01, aux pins, strap code
// - address fixed at boot before responding
`include "ihp_cfg.svh"

// link-side target engine of one host port, on the oversampling link clock
module ihp_link (
   input wire logic link_clk,
   input wire logic rst_n,
   input wire logic master_mode,
   input wire logic bb_clock_low,
   input wire logic bb_data_low,
   input wire logic [6:0] addr,
   input wire logic addr_valid,
   input wire logic ack_t,
   input wire logic [7:0] tx_byte,
   input wire logic clock_in,
   input wire logic data_in,
   output logic clock_out,
   output logic clock_drv_n,
   output logic data_out,
   output logic data_drv_n,
   output logic req_t,
   output logic req_rd,
   output logic [7:0] rx_byte,
   output logic hit_t,
   output logic stop_t
);
   ihp_pkg::ihp_link_t r, n; // whole state and its next value
   logic fall, rise, start, stop, ackseen; // decoded bus events

   // next-state logic; reset is synchronous after the reset is re-timed here
   always_comb begin
      n = r;
      // two-stage synchronisers; only the second stage is read below
      n.rst_s1 = rst_n;
      n.rst_s2 = r.rst_s1;
      // fast rate: 32 ns sampling leaves margin in a 600 ns high phase
      n.scl_s1 = clock_in;
      n.scl_s2 = r.scl_s1;
      n.sda_s1 = data_in;
      n.sda_s2 = r.sda_s1;
      n.scl_q = r.scl_s2;
      n.sda_q = r.sda_s2;
      n.mst_s1 = master_mode;
      n.mst_s2 = r.mst_s1;
      n.bbc_s1 = bb_clock_low;
      n.bbc_s2 = r.bbc_s1;
      n.bbd_s1 = bb_data_low;
      n.bbd_s2 = r.bbd_s1;
      n.av_s1 = addr_valid;
      n.av_s2 = r.av_s1;
      n.ack_s1 = ack_t;
      n.ack_s2 = r.ack_s1;
      n.pin_zero = 1'b0;
      fall = r.scl_q & ~r.scl_s2;
      rise = ~r.scl_q & r.scl_s2;
      start = r.scl_q & r.scl_s2 & r.sda_q & ~r.sda_s2;
      stop = r.scl_q & r.scl_s2 & ~r.sda_q & r.sda_s2;
      // core has answered the last request once its toggle matches ours
      ackseen = (r.ack_s2 == r.req_t);
      if (r.mst_s2) begin
         // master mode: engine parked, pins follow the core's bitbang levels
         n.st = ihp_pkg::IHP_IDLE;
         n.clock_drv_n = ~r.bbc_s2;
         n.data_drv_n = ~r.bbd_s2;
      end else if (!r.av_s2) begin
         // deaf until the address has been fixed
         n.st = ihp_pkg::IHP_IDLE;
         n.clock_drv_n = 1'b1;
         n.data_drv_n = 1'b1;
      end else if (start) begin
         // start or repeated start opens address phase
         n.st = ihp_pkg::IHP_ADDR;
         n.bitcnt = 4'h0;
         n.data_drv_n = 1'b1;
         n.clock_drv_n = 1'b1;
      end else if (stop) begin
         // stop ends the transaction; report it only if we took part and no nack had sent us to ignore
         if (r.st != ihp_pkg::IHP_IDLE && r.st != ihp_pkg::IHP_IGNORE
             && r.st != ihp_pkg::IHP_ADDR) begin
            n.stop_t = ~r.stop_t;
         end
         n.st = ihp_pkg::IHP_IDLE;
         n.data_drv_n = 1'b1;
         n.clock_drv_n = 1'b1;
      end else begin
         case (r.st)
            ihp_pkg::IHP_ADDR, ihp_pkg::IHP_WDATA: begin
               // bits arrive msb first and shift in on the rising edge
               if (rise) begin
                  n.shreg = {r.shreg[6:0], r.sda_s2};
                  n.bitcnt = r.bitcnt + 4'h1;
               end
               // after eight bits the ninth clock is the ack
               if (fall && r.bitcnt == `IHP_BYTE_BITS) begin
                  if (r.st == ihp_pkg::IHP_WDATA) begin
                     n.data_drv_n = 1'b0;
                     n.rx_byte = r.shreg;
                     n.st = ihp_pkg::IHP_WACK;
                  end else if (r.shreg[7:1] == addr) begin
                     n.data_drv_n = 1'b0;
                     n.rw = r.shreg[0];
                     n.hit_t = ~r.hit_t;
                     n.st = ihp_pkg::IHP_AACK;
                  end else begin
                     // foreign address: stay off the bus
                     n.st = ihp_pkg::IHP_IGNORE;
                  end
               end
            end
            ihp_pkg::IHP_AACK: begin
               if (fall) begin
                  n.data_drv_n = 1'b1;
                  n.bitcnt = 4'h0;
                  if (r.rw) begin
                     // stretch while the core fetches the first byte
                     n.clock_drv_n = 1'b0;
                     n.req_t = ~r.req_t;
                     n.req_rd = 1'b1;
                     n.st = ihp_pkg::IHP_RFETCH;
                  end else begin
                     n.st = ihp_pkg::IHP_WDATA;
                  end
               end
            end
            ihp_pkg::IHP_WACK: begin
               if (fall) begin
                  // hold clock low until the core has taken the byte
                  n.data_drv_n = 1'b1;
                  n.clock_drv_n = 1'b0;
                  n.req_t = ~r.req_t;
                  n.req_rd = 1'b0;
                  n.st = ihp_pkg::IHP_WWAIT;
               end
            end
            ihp_pkg::IHP_WWAIT: begin
               if (ackseen) begin
                  n.clock_drv_n = 1'b1;
                  n.bitcnt = 4'h0;
                  n.st = ihp_pkg::IHP_WDATA;
               end
            end
            ihp_pkg::IHP_RFETCH: begin
               // first bit placed while clock is still held low
               if (ackseen) begin
                  n.data_drv_n = tx_byte[7];
                  n.shreg = {tx_byte[6:0], 1'b0};
                  n.bitcnt = 4'h1;
                  // clock stays held here; it is let go one cycle later so data is settled
                  n.st = ihp_pkg::IHP_RDATA;
               end
            end
            ihp_pkg::IHP_RDATA: begin
               // release the stretch only after the first bit stands
               if (!r.clock_drv_n) begin
                  n.clock_drv_n = 1'b1;
               end
               if (fall) begin
                  if (r.bitcnt == `IHP_BYTE_BITS) begin
                     // release data for the master's ack
                     n.data_drv_n = 1'b1;
                     n.st = ihp_pkg::IHP_RACK;
                  end else begin
                     // next bit moves only after a falling edge
                     n.data_drv_n = r.shreg[7];
                     n.shreg = {r.shreg[6:0], 1'b0};
                     n.bitcnt = r.bitcnt + 4'h1;
                  end
               end
            end
            ihp_pkg::IHP_RACK: begin
               if (rise && r.sda_s2) begin
                  // nack marks the last byte; keep data released
                  n.st = ihp_pkg::IHP_IGNORE;
               end else if (fall) begin
                  // stretch right after the ack for the next byte
                  n.clock_drv_n = 1'b0;
                  n.req_t = ~r.req_t;
                  n.req_rd = 1'b1;
                  n.st = ihp_pkg::IHP_RFETCH;
               end
            end
            default: begin
               // idle and ignore: lines released, wait for start
               n.data_drv_n = 1'b1;
               n.clock_drv_n = 1'b1;
            end
         endcase
      end
      if (!r.rst_s2) begin
         n = '0;
         n.rst_s1 = rst_n;
         n.rst_s2 = r.rst_s1;
         n.st = ihp_pkg::IHP_IDLE;
         n.clock_drv_n = 1'b1;
         n.data_drv_n = 1'b1;
         n.scl_q = 1'b1;
         n.sda_q = 1'b1;
         // syncs sit at the idle bus level so no false edge follows reset
         n.scl_s1 = 1'b1;
         n.scl_s2 = 1'b1;
         n.sda_s1 = 1'b1;
         n.sda_s2 = 1'b1;
      end
   end

   // single state register of the link domain
   always_ff @(posedge link_clk) begin
      r <= n;
   end

   assign clock_out = r.pin_zero;
   assign clock_drv_n = r.clock_drv_n;
   assign data_out = r.pin_zero;
   assign data_drv_n = r.data_drv_n;
   assign req_t = r.req_t;
   assign req_rd = r.req_rd;
   assign rx_byte = r.rx_byte;
   assign hit_t = r.hit_t;
   assign stop_t = r.stop_t;

   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!r.rst_s2);

   a_start_opens_addr: assert property (
      (!r.mst_s2 && r.av_s2 && start) |=> (r.st == ihp_pkg::IHP_ADDR && r.bitcnt == 4'h0))
      else $error("start did not open address phase");
   a_stop_to_idle: assert property (
      (!r.mst_s2 && r.av_s2 && !start && stop) |=> (r.st == ihp_pkg::IHP_IDLE && r.data_drv_n))
      else $error("stop did not return engine to idle");
   a_addr_match_ack: assert property (
      (!r.mst_s2 && r.av_s2 && !start && !stop && r.st == ihp_pkg::IHP_ADDR && fall
       && r.bitcnt == 4'h8 && r.shreg[7:1] == addr)
      |=> (!r.data_drv_n ##1 !r.data_drv_n))
      else $error("matching address not acked");
   a_addr_miss_off: assert property (
      (!r.mst_s2 && r.av_s2 && !start && !stop && r.st == ihp_pkg::IHP_ADDR && fall
       && r.bitcnt == 4'h8 && r.shreg[7:1] != addr)
      |=> (r.st == ihp_pkg::IHP_IGNORE && r.data_drv_n))
      else $error("foreign address touched the bus");
   a_write_byte_ack: assert property (
      (!r.mst_s2 && r.av_s2 && !start && !stop && r.st == ihp_pkg::IHP_WDATA && fall
       && r.bitcnt == 4'h8) |=> (!r.data_drv_n && r.rx_byte == $past(r.shreg)))
      else $error("received byte not acked");
   a_data_moves_low: assert property (
      (!r.mst_s2 && $past(r.rst_s2) && !$past(r.mst_s2) && $fell(r.data_drv_n))
      |-> !$past(r.scl_s2))
      else $error("target drove data low while clock high");
   a_nack_release: assert property (
      (!r.mst_s2 && r.av_s2 && !start && !stop && r.st == ihp_pkg::IHP_RACK && rise
       && r.sda_s2) |=> (r.st == ihp_pkg::IHP_IGNORE) ##1 r.data_drv_n)
      else $error("data not released after nack");
   a_stretch_hold: assert property (
      (!r.mst_s2 && (r.st == ihp_pkg::IHP_WWAIT || r.st == ihp_pkg::IHP_RFETCH)
       && !ackseen && !start && !stop) |=> !r.clock_drv_n)
      else $error("clock released before core answered");
   a_deaf_before_addr: assert property (
      (!r.mst_s2 && !r.av_s2) |=> (r.clock_drv_n && r.data_drv_n))
      else $error("port answered before address was fixed");
endmodule

// core-domain side of one host port: byte handshake, events, masked irq
module ihp_side (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_t,
   input wire logic req_rd,
   input wire logic [7:0] link_rx_byte,
   input wire logic hit_t,
   input wire logic stop_t,
   input wire logic [3:0] irq_mask,
   input wire logic [3:0] ev_clear,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic ack_t,
   output logic [7:0] tx_byte,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_taken,
   output logic [3:0] events,
   output logic irq_n
);
   ihp_pkg::ihp_side_t r, n; // whole state and its next value
   logic [3:0] ev_set; // events raised this cycle

   // toggles cross by two flops; held bytes are stable while a toggle is open
   always_comb begin
      n = r;
      ev_set = 4'h0;
      n.req_s1 = req_t;
      n.req_s2 = r.req_s1;
      n.hit_s1 = hit_t;
      n.hit_s2 = r.hit_s1;
      n.stop_s1 = stop_t;
      n.stop_s2 = r.stop_s1;
      n.rx_valid = 1'b0;
      n.tx_taken = 1'b0;
      if (r.req_s2 != r.req_q) begin
         n.req_q = r.req_s2;
         n.pend = 1'b1;
         n.pend_rd = req_rd;
         ev_set[`IHP_EV_TXREQ] = req_rd;
      end
      if (r.pend && r.pend_rd && tx_valid) begin
         // byte registered with the ack toggle; the link reads it settled after the toggle's two-flop sync
         n.tx_byte = tx_data;
         n.tx_taken = 1'b1;
         n.ack_t = ~r.ack_t;
         n.pend = 1'b0;
      end else if (r.pend && !r.pend_rd && rx_ready) begin
         n.rx_data = link_rx_byte;
         n.rx_valid = 1'b1;
         n.ack_t = ~r.ack_t;
         n.pend = 1'b0;
         ev_set[`IHP_EV_RX] = 1'b1;
      end
      if (r.hit_s2 != r.hit_q) begin
         n.hit_q = r.hit_s2;
         ev_set[`IHP_EV_HIT] = 1'b1;
      end
      if (r.stop_s2 != r.stop_q) begin
         n.stop_q = r.stop_s2;
         ev_set[`IHP_EV_STOP] = 1'b1;
      end
      // a set in the clearing cycle wins
      n.events = (r.events & ~ev_clear) | ev_set;
      // only unmasked events pull this port's irq low
      n.irq_n = ~|(n.events & irq_mask);
   end

   // single state register of the core side
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
         r.irq_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign ack_t = r.ack_t;
   assign tx_byte = r.tx_byte;
   assign rx_valid = r.rx_valid;
   assign rx_data = r.rx_data;
   assign tx_taken = r.tx_taken;
   assign events = r.events;
   assign irq_n = r.irq_n;

   a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
      ((r.events & irq_mask) != 4'h0 && $stable(irq_mask)) |-> !r.irq_n)
      else $error("unmasked pending event did not raise irq");
endmodule

// top: two host ports, address straps and the firmware-driven aux master
module ihp_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic host_port_a_clock_in,
   output logic host_port_a_clock_out,
   output logic host_port_a_clock_drv_n,
   input wire logic host_port_a_data_in,
   output logic host_port_a_data_out,
   output logic host_port_a_data_drv_n,
   output logic host_port_a_irq_n,
   input wire logic host_port_b_clock_in,
   output logic host_port_b_clock_out,
   output logic host_port_b_clock_drv_n,
   input wire logic host_port_b_data_in,
   output logic host_port_b_data_out,
   output logic host_port_b_data_drv_n,
   output logic host_port_b_irq_n,
   input wire logic aux_master_clock_pin_in,
   output logic aux_master_clock_pin_out,
   output logic aux_master_clock_pin_drv_n,
   input wire logic aux_master_data_pin_in,
   output logic aux_master_data_pin_out,
   output logic aux_master_data_pin_drv_n,
   input wire logic aux_clock_low,
   input wire logic aux_data_low,
   input wire logic [2:0] addr_strap_code,
   input wire logic [1:0] port_master_mode,
   input wire logic [1:0] port_bb_clock_low,
   input wire logic [1:0] port_bb_data_low,
   input wire logic [1:0][3:0] port_irq_mask,
   input wire logic [1:0][3:0] port_ev_clear,
   input wire logic [1:0] port_rx_ready,
   input wire logic [1:0] port_tx_valid,
   input wire logic [1:0][7:0] port_tx_data,
   output logic [1:0] port_rx_valid,
   output logic [1:0][7:0] port_rx_data,
   output logic [1:0] port_tx_taken,
   output logic [1:0][3:0] port_events,
   output logic [1:0] port_clock_level,
   output logic [1:0] port_data_level,
   output logic aux_clock_level,
   output logic aux_data_level,
   output logic [6:0] target_addr,
   output logic target_addr_valid
);
   ihp_pkg::ihp_top_t r, n; // whole state and its next value
   logic [1:0] clk_in_w, dat_in_w, clk_out_w, clk_drv_w, dat_out_w, dat_drv_w;
   logic [1:0] irq_w, req_w, rd_w, hit_w, stop_w, ack_w;
   logic [1:0][7:0] rxb_w, txb_w;

   assign clk_in_w = {host_port_b_clock_in, host_port_a_clock_in};
   assign dat_in_w = {host_port_b_data_in, host_port_a_data_in};

   // both ports are the same engine, one per generate entry
   for (genvar i = 0; i < 2; i++) begin : g_port
      ihp_link u_link (
         .link_clk(link_clk), .rst_n(rst_n), .master_mode(port_master_mode[i]),
         .bb_clock_low(port_bb_clock_low[i]), .bb_data_low(port_bb_data_low[i]),
         .addr(r.addr), .addr_valid(r.addr_valid), .ack_t(ack_w[i]),
         .tx_byte(txb_w[i]), .clock_in(clk_in_w[i]), .data_in(dat_in_w[i]),
         .clock_out(clk_out_w[i]), .clock_drv_n(clk_drv_w[i]),
         .data_out(dat_out_w[i]), .data_drv_n(dat_drv_w[i]), .req_t(req_w[i]),
         .req_rd(rd_w[i]), .rx_byte(rxb_w[i]), .hit_t(hit_w[i]), .stop_t(stop_w[i]));
      ihp_side u_side (
         .clk(clk), .rst_n(rst_n), .req_t(req_w[i]), .req_rd(rd_w[i]),
         .link_rx_byte(rxb_w[i]), .hit_t(hit_w[i]), .stop_t(stop_w[i]),
         .irq_mask(port_irq_mask[i]), .ev_clear(port_ev_clear[i]),
         .rx_ready(port_rx_ready[i]), .tx_valid(port_tx_valid[i]),
         .tx_data(port_tx_data[i]), .ack_t(ack_w[i]), .tx_byte(txb_w[i]),
         .rx_valid(port_rx_valid[i]), .rx_data(port_rx_data[i]),
         .tx_taken(port_tx_taken[i]), .events(port_events[i]), .irq_n(irq_w[i]));
   end

   // straps, aux master drive and synchronised pin levels
   always_comb begin
      n = r;
      n.auxc_s1 = aux_master_clock_pin_in;
      n.auxc_s2 = r.auxc_s1;
      n.auxd_s1 = aux_master_data_pin_in;
      n.auxd_s2 = r.auxd_s1;
      n.pc_s1 = clk_in_w;
      n.pc_s2 = r.pc_s1;
      n.pd_s1 = dat_in_w;
      n.pd_s2 = r.pd_s1;
      n.pin_zero = 1'b0;
      if (!r.addr_valid) begin
         // aux pins released so their strap levels can settle through the syncs
         n.auxc_drv_n = 1'b1;
         n.auxd_drv_n = 1'b1;
         if (r.boot_cnt == `IHP_BOOT_WAIT) begin
            // address built from fixed bits, aux pin levels and strap
            n.addr = {`IHP_ADDR_TOP, r.auxd_s2, r.auxc_s2, addr_strap_code};
            // latched once; ports stay deaf until this is set
            n.addr_valid = 1'b1;
         end else begin
            n.boot_cnt = r.boot_cnt + 2'h1;
         end
      end else begin
         // aux port is plain bitbang, no protocol hardware, no irq
         // first aux pin carries clock, second carries data
         n.auxc_drv_n = ~aux_clock_low;
         n.auxd_drv_n = ~aux_data_low;
      end
   end

   // single state register of the top
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
         r.auxc_drv_n <= 1'b1;
         r.auxd_drv_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign host_port_a_clock_out = clk_out_w[0];
   assign host_port_a_clock_drv_n = clk_drv_w[0];
   assign host_port_a_data_out = dat_out_w[0];
   assign host_port_a_data_drv_n = dat_drv_w[0];
   assign host_port_a_irq_n = irq_w[0];
   assign host_port_b_clock_out = clk_out_w[1];
   assign host_port_b_clock_drv_n = clk_drv_w[1];
   assign host_port_b_data_out = dat_out_w[1];
   assign host_port_b_data_drv_n = dat_drv_w[1];
   assign host_port_b_irq_n = irq_w[1];
   assign aux_master_clock_pin_out = r.pin_zero;
   assign aux_master_clock_pin_drv_n = r.auxc_drv_n;
   assign aux_master_data_pin_out = r.pin_zero;
   assign aux_master_data_pin_drv_n = r.auxd_drv_n;
   assign port_clock_level = r.pc_s2;
   assign port_data_level = r.pd_s2;
   assign aux_clock_level = r.auxc_s2;
   assign aux_data_level = r.auxd_s2;
   assign target_addr = r.addr;
   assign target_addr_valid = r.addr_valid;

   a_addr_layout: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(r.addr_valid) |-> (r.addr == {2'b01, $past(r.auxd_s2), $past(r.auxc_s2),
                                          $past(addr_strap_code)}))
      else $error("target address not built from straps");
endmodule

// ### include/ihp_cfg.svh
`ifndef IHP_CFG_SVH
`define IHP_CFG_SVH
// fixed upper two address bits of the target address
`define IHP_ADDR_TOP 2'b01
// bits in one byte on the wire
`define IHP_BYTE_BITS 4'h8
// event bit positions in the per-port event vector
`define IHP_EV_HIT 0
`define IHP_EV_STOP 1
`define IHP_EV_RX 2
`define IHP_EV_TXREQ 3
// number of event kinds per port
`define IHP_EV_NUM 4
// core cycles to wait after reset before the straps are trusted
`define IHP_BOOT_WAIT 2'h3
`endif

// ### include/ihp_pkg.sv
package ihp_pkg;
   // target engine states on the link side
   typedef enum logic [3:0] {
      IHP_IDLE, IHP_ADDR, IHP_AACK, IHP_WDATA, IHP_WACK,
      IHP_WWAIT, IHP_RFETCH, IHP_RDATA, IHP_RACK, IHP_IGNORE
   } ihp_state_t;
   // link-domain state of one host port
   typedef struct packed {
      logic rst_s1, rst_s2;
      logic scl_s1, scl_s2, sda_s1, sda_s2, scl_q, sda_q;
      logic mst_s1, mst_s2, bbc_s1, bbc_s2, bbd_s1, bbd_s2, av_s1, av_s2;
      logic ack_s1, ack_s2;
      ihp_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw, req_t, req_rd, hit_t, stop_t;
      logic [7:0] rx_byte;
      logic clock_drv_n, data_drv_n, pin_zero;
   } ihp_link_t;
   // core-domain state of one host port
   typedef struct packed {
      logic req_s1, req_s2, req_q, hit_s1, hit_s2, hit_q, stop_s1, stop_s2, stop_q;
      logic pend, pend_rd, ack_t;
      logic [7:0] tx_byte, rx_data;
      logic rx_valid, tx_taken;
      logic [3:0] events;
      logic irq_n;
   } ihp_side_t;
   // core-domain state of the top: strap capture, aux master, pin levels
   typedef struct packed {
      logic auxc_s1, auxc_s2, auxd_s1, auxd_s2;
      logic [1:0] pc_s1, pc_s2, pd_s1, pd_s2;
      logic [1:0] boot_cnt;
      logic addr_valid;
      logic [6:0] addr;
      logic auxc_drv_n, auxd_drv_n, pin_zero;
   } ihp_top_t;
endpackage

// ### test/ihp_bus_master.sv
// behavioural host-side bus master on one open-drain port
module ihp_bus_master #(parameter int HP = 1250) (
   input wire logic scl,
   input wire logic sda,
   output logic scl_drv_n,
   output logic sda_drv_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // both lines released at power-up, the pull-ups make the bus idle
   initial begin
      scl_drv_n = 1'b1;
      sda_drv_n = 1'b1;
   end
   task automatic rise();
      int i;
      scl_drv_n = 1'b1;
      i = 0;
      while (scl !== 1'b1 && i < 20000) begin
         #10;
         i++;
      end
   endtask
   task automatic bit_io(input logic b, output logic r);
      #(HP / 4) sda_drv_n = b;
      #(HP * 3 / 4);
      rise();
      #HP;
      r = sda;
      scl_drv_n = 1'b0;
   endtask
   task automatic start();
      sda_drv_n = 1'b1;
      rise();
      #HP sda_drv_n = 1'b0;
      #HP scl_drv_n = 1'b0;
   endtask
   task automatic stop();
      #(HP / 4) sda_drv_n = 1'b0;
      #(HP * 3 / 4);
      rise();
      #HP sda_drv_n = 1'b1;
      #HP;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ab, a);
   endtask
endmodule

// ### test/test_i2c_target_host_port.sv
// self-checking bench: port a talks to the bus master model
module test_i2c_target_host_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, link_clk, m_scl_n, m_sda_n, a, aux_clock_low, aux_data_low;
   logic host_port_a_clock_in, host_port_a_clock_out, host_port_a_clock_drv_n;
   logic host_port_a_data_in, host_port_a_data_out, host_port_a_data_drv_n, host_port_a_irq_n;
   logic host_port_b_clock_in, host_port_b_clock_out, host_port_b_clock_drv_n;
   logic host_port_b_data_in, host_port_b_data_out, host_port_b_data_drv_n, host_port_b_irq_n;
   logic aux_master_clock_pin_in, aux_master_clock_pin_out, aux_master_clock_pin_drv_n;
   logic aux_master_data_pin_in, aux_master_data_pin_out, aux_master_data_pin_drv_n;
   logic aux_clock_level, aux_data_level, target_addr_valid;
   logic [1:0] port_master_mode, port_bb_clock_low, port_bb_data_low, port_rx_ready;
   logic [1:0] port_tx_valid, port_rx_valid, port_tx_taken, port_clock_level, port_data_level;
   logic [1:0][3:0] port_irq_mask, port_ev_clear, port_events;
   logic [1:0][7:0] port_tx_data, port_rx_data;
   logic [2:0] addr_strap_code;
   logic [6:0] target_addr, ta;
   logic [7:0] got, q, d, tk;
   int n_mismatch = 0, checks = 0, cyc = 0;
   // wired-and buses with pull-ups, port b and aux pins see only the device
   assign host_port_a_clock_in = host_port_a_clock_drv_n & m_scl_n;
   assign host_port_a_data_in = host_port_a_data_drv_n & m_sda_n;
   assign host_port_b_clock_in = host_port_b_clock_drv_n;
   assign host_port_b_data_in = host_port_b_data_drv_n;
   assign aux_master_clock_pin_in = aux_master_clock_pin_drv_n;
   assign aux_master_data_pin_in = aux_master_data_pin_drv_n;
   ihp_top ihp_top_i (.*);
   ihp_bus_master ihp_bus_master_i (.scl(host_port_a_clock_in), .sda(host_port_a_data_in),
      .scl_drv_n(m_scl_n), .sda_drv_n(m_sda_n));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // link clock unrelated in phase to the core clock
   initial begin
      link_clk = 1'b0;
      #5;
      forever #16 link_clk = ~link_clk;
   end
   // expected address: fixed top bits, released aux pins read high, strap code
   function automatic logic [6:0] exp_addr(input logic [2:0] s);
      return {2'b01, 1'b1, 1'b1, s};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // capture received bytes, cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (port_rx_valid[0] === 1'b1) got <= port_rx_data[0];
      if (port_tx_taken[0] === 1'b1) tk <= port_tx_data[0];
      if (cyc == 60000) begin
         n_mismatch++;
         conclude();
      end
   end
   // one transfer: start, address byte, one data byte if the address was acked, stop
   task automatic txn(input logic [7:0] ab, input logic [7:0] db, input logic aexp);
      ihp_bus_master_i.start();
      ihp_bus_master_i.xfer(ab, 1'b1, q, a);
      check({7'h0, a}, {7'h0, aexp});
      if (!a) ihp_bus_master_i.xfer(db, 1'b1, q, a);
      ihp_bus_master_i.stop();
      repeat (30) @(posedge clk);
      #1;
   endtask
   task automatic clear();
      port_ev_clear[0] = 4'hf;
      @(posedge clk) #1 port_ev_clear[0] = 4'h0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   initial begin
      void'($urandom(32'hbb93));
      {rst_n, aux_clock_low, aux_data_low, port_master_mode, port_bb_clock_low} = '0;
      {port_bb_data_low, port_ev_clear, port_tx_valid, port_tx_data} = '0;
      port_rx_ready = 2'b11;
      port_irq_mask = {4'h0, 4'h4};
      addr_strap_code = 3'($urandom);
      ta = exp_addr(addr_strap_code);
      // six core cycles also span a link clock edge
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (60) @(posedge clk);
      #1;
      check({target_addr_valid, target_addr}, {1'b1, ta});
      d = 8'($urandom);
      txn({ta, 1'b0}, d, 1'b0);
      check({7'h0, a}, 8'h0);
      check(got, d);
      check({port_events[0], 3'h0, host_port_a_irq_n}, 8'h70);
      clear();
      check({port_events[0], 3'h0, host_port_a_irq_n}, 8'h01);
      d = 8'($urandom);
      port_tx_data[0] = d;
      port_tx_valid[0] = 1'b1;
      ihp_bus_master_i.start();
      ihp_bus_master_i.xfer({ta, 1'b1}, 1'b1, q, a);
      check({7'h0, a}, 8'h0);
      ihp_bus_master_i.xfer(8'hff, 1'b0, q, a);
      check(q, d);
      ihp_bus_master_i.xfer(8'hff, 1'b1, q, a);
      check(q, d);
      ihp_bus_master_i.stop();
      repeat (30) @(posedge clk);
      #1 port_tx_valid[0] = 1'b0;
      check({port_events[0], 3'h0, host_port_a_irq_n}, 8'h91);
      check(tk, d);
      clear();
      txn({ta ^ 7'h01, 1'b0}, 8'h00, 1'b1);
      check({4'h0, port_events[0]}, 8'h00);
      // port b as bitbang master, aux clock pulled low
      aux_clock_low = 1'b1;
      port_master_mode[1] = 1'b1;
      port_bb_data_low[1] = 1'b1;
      repeat (30) @(posedge clk);
      #1;
      check({6'h0, aux_master_clock_pin_drv_n, aux_clock_level}, 8'h00);
      check({6'h0, aux_master_data_pin_drv_n, aux_data_level}, 8'h03);
      check({4'h0, port_clock_level, port_data_level}, 8'h0d);
      check({host_port_a_clock_out, host_port_a_data_out, host_port_b_clock_out,
             host_port_b_data_out, aux_master_clock_pin_out, aux_master_data_pin_out,
             host_port_b_irq_n, 1'b0}, 8'h02);
      conclude();
   end
endmodule
